// ===== shared/tbw_pkg.sv
// constants, types and carrier for the touch button and wheel detector
// assumes one 20 MHz clock and an analog front end driven by strobes
package tbw_pkg;
  localparam int NS = 12;
  localparam int TW = 16;
  localparam int AW = 8;
  // register byte addresses
  localparam logic [AW-1:0] A_MODE = 8'h00;
  localparam logic [AW-1:0] A_EN = 8'h04;
  localparam logic [AW-1:0] A_WHL = 8'h08;
  localparam logic [AW-1:0] A_THR = 8'h0c;
  localparam logic [AW-1:0] A_WPOS = 8'h10;
  localparam logic [AW-1:0] A_PER = 8'h14;
  localparam logic [AW-1:0] A_TMO = 8'h18;
  localparam logic [AW-1:0] A_WAKE = 8'h1c;
  localparam logic [AW-1:0] A_SENS = 8'h20;
  localparam logic [AW-1:0] A_DCV = 8'h24;
  localparam logic [AW-1:0] A_STAT = 8'h28;
  localparam logic [AW-1:0] A_POS = 8'h2c;
  // reset values
  localparam logic [11:0] EN_RST = 12'hfff;
  localparam logic [11:0] WHL_RST = 12'hfc0;
  localparam logic [31:0] THR_RST = 32'h0008_0040;
  localparam logic [31:0] WPOS_RST = 32'h0008_00ff;
  localparam logic [31:0] PER_RST = 32'h00c3_001e;
  localparam logic [15:0] TMO_RST = 16'h0064;
  localparam logic [31:0] WAKE_RST = 32'h0000_0000;
  localparam logic [23:0] SENS_RST = 24'h00_0000;
  // field positions
  localparam int F_HI = 16;
  localparam int WK_EN = 31;
  localparam int WK_LEN = 16;
  localparam int DCV_IX = 16;
  // charge accumulations per conversion cycle
  localparam int ACC_N = 4;
  localparam logic [2:0] ACC_LAST = 3'(ACC_N - 1);
  // scan period unit: one millisecond
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 50;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum logic [1:0] {
    MD_ACT = 2'b00,
    MD_DOZE = 2'b01,
    MD_SLEEP = 2'b10
  } tbw_mode_e;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_SEL = 3'b001,
    PH_ACC = 3'b010,
    PH_DAC = 3'b011,
    PH_XFR = 3'b100,
    PH_STORE = 3'b101,
    PH_PROC = 3'b110,
    PH_WAIT = 3'b111
  } tbw_phase_e;
  typedef struct packed {
    logic [3:0] sel;
    logic clr;
    logic accum;
    logic dac_en;
    logic xfer;
    logic [TW-1:0] dac;
  } tbw_afe_s;
endpackage

// ===== logic/tbw_detect.sv
// touch button and wheel detector with AXI4-Lite registers
// assumes the front end converts on the strobes and holds afe_ticks
module tbw_detect import tbw_pkg::*; #(
  parameter int unsigned MS_CYC = CYC_PER_MS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output tbw_afe_s afe_ctl,
  input wire logic [TW-1:0] afe_ticks,
  output logic host_interrupt_n
);
  localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);
  logic [1:0] rs_ff;
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic awready_ff, wready_ff, arready_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  tbw_mode_e mode_ff;
  logic [11:0] en_ff, whl_ff, on_ff, nxt_on;
  logic [31:0] thr_ff, wpos_ff, per_ff, wake_ff;
  logic [15:0] tmo_ff, idle_ff, pos_ff, msc_ff, tmr_ff;
  logic [23:0] sens_ff;
  logic [TW-1:0] tick_ff [NS];
  logic [TW-1:0] dcv_ff [NS];
  tbw_phase_e ph_ff, nxt_ph;
  logic [3:0] idx_ff, nxt_idx;
  logic [1:0] cyc_ff, nxt_cyc;
  logic [2:0] acc_ff, nxt_acc, wk_ff;
  logic wh_on_ff, cw_ff, ccw_ff, irq_n_ff;
  logic [16:0] stat_ff;
  tbw_afe_s afe_ff, nxt_afe;
  logic [23:0] num;
  logic [19:0] den;
  logic [3:0] rank;
  logic [39:0] pos_w;
  wire rstn = rs_ff[1];

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rs_ff <= 2'b00;
    else rs_ff <= {rs_ff[0], 1'b1};
  end

  // bus handshakes
  wire aw_ok = s_axi_awvalid & awready_ff;
  wire w_ok = s_axi_wvalid & wready_ff;
  wire ar_ok = s_axi_arvalid & arready_ff;
  wire wr_do = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire nxt_aw_got = ~wr_do & (aw_got_ff | aw_ok);
  wire nxt_w_got = ~wr_do & (w_got_ff | w_ok);
  wire nxt_bvalid = wr_do | (bvalid_ff & ~s_axi_bready);
  wire nxt_rvalid = ar_ok | (rvalid_ff & ~s_axi_rready);
  wire [AW-1:0] wa = awaddr_ff;
  wire [AW-1:0] ra = s_axi_araddr;
  wire wr_hit = wa inside {A_MODE, A_EN, A_WHL, A_THR, A_WPOS,
    A_PER, A_TMO, A_WAKE, A_SENS, A_DCV, A_STAT, A_POS};
  wire rd_hit = ra inside {A_MODE, A_EN, A_WHL, A_THR, A_WPOS,
    A_PER, A_TMO, A_WAKE, A_SENS, A_DCV, A_STAT, A_POS};
  wire [31:0] wm = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
    {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire we_mode = wr_do & (wa == A_MODE) & (wdata_ff[1:0] != 2'b11);
  wire [31:0] rmux =
    (ra == A_MODE) ? 32'(mode_ff) :
    (ra == A_EN) ? 32'(en_ff) :
    (ra == A_WHL) ? 32'(whl_ff) :
    (ra == A_THR) ? thr_ff :
    (ra == A_WPOS) ? wpos_ff :
    (ra == A_PER) ? per_ff :
    (ra == A_TMO) ? 32'(tmo_ff) :
    (ra == A_WAKE) ? wake_ff :
    (ra == A_SENS) ? 32'(sens_ff) :
    (ra == A_STAT) ? 32'(stat_ff) :
    (ra == A_POS) ? 32'(pos_ff) : 32'h0000_0000;

  function automatic logic [31:0] bm(input logic [31:0] o);
    return (o & ~wm) | (wdata_ff & wm);
  endfunction

  // bus channel state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bresp_ff <= RESP_OK;
      rresp_ff <= RESP_OK;
      rdata_ff <= '0;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got & ~nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
      if (aw_ok) awaddr_ff <= s_axi_awaddr;
      if (w_ok) wdata_ff <= s_axi_wdata;
      if (w_ok) wstrb_ff <= s_axi_wstrb;
      if (wr_do) bresp_ff <= wr_hit ? RESP_OK : RESP_ERR;
      if (ar_ok) rdata_ff <= rmux;
      if (ar_ok) rresp_ff <= rd_hit ? RESP_OK : RESP_ERR;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_ff <= EN_RST;
      whl_ff <= WHL_RST;
      thr_ff <= THR_RST;
      wpos_ff <= WPOS_RST;
      per_ff <= PER_RST;
      tmo_ff <= TMO_RST;
      wake_ff <= WAKE_RST;
      sens_ff <= SENS_RST;
    end else if (wr_do) begin
      if (wa == A_EN) en_ff <= 12'(bm(32'(en_ff)));
      if (wa == A_WHL) whl_ff <= 12'(bm(32'(whl_ff)));
      if (wa == A_THR) thr_ff <= bm(thr_ff);
      if (wa == A_WPOS) wpos_ff <= bm(wpos_ff);
      if (wa == A_PER) per_ff <= bm(per_ff);
      if (wa == A_TMO) tmo_ff <= 16'(bm(32'(tmo_ff)));
      if (wa == A_WAKE) wake_ff <= bm(wake_ff);
      if (wa == A_SENS) sens_ff <= 24'(bm(32'(sens_ff)));
    end
  end

  // offset levels loaded by the compensation procedure
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NS; i++) dcv_ff[i] <= '0;
    end else if (wr_do && wa == A_DCV
                 && wdata_ff[DCV_IX +: 4] < 4'(NS)) begin
      dcv_ff[wdata_ff[DCV_IX +: 4]] <= wdata_ff[TW-1:0];
    end
  end

  // scan sequencing
  wire last = (idx_ff == 4'(NS));
  wire [1:0] sens_cur = sens_ff[{idx_ff, 1'b0} +: 2];
  wire [15:0] per_cur = (mode_ff == MD_DOZE) ?
    per_ff[F_HI +: 16] : per_ff[15:0];
  always_comb begin
    nxt_ph = ph_ff;
    nxt_idx = idx_ff;
    nxt_cyc = cyc_ff;
    nxt_acc = acc_ff;
    case (ph_ff)
      PH_IDLE: if (mode_ff != MD_SLEEP) begin
        nxt_ph = PH_SEL;
        nxt_idx = 4'h0;
      end
      PH_SEL: if (last) begin
        nxt_ph = PH_PROC;
      end else if (en_ff[idx_ff]) begin
        nxt_ph = PH_ACC;
        nxt_cyc = 2'h0;
        nxt_acc = 3'h0;
      end else begin
        nxt_idx = idx_ff + 4'h1;
      end
      PH_ACC: if (acc_ff == ACC_LAST) begin
        nxt_ph = PH_DAC;
      end else begin
        nxt_acc = acc_ff + 3'h1;
      end
      PH_DAC: nxt_ph = PH_XFR;
      PH_XFR: if (cyc_ff == sens_cur) begin
        nxt_ph = PH_STORE;
      end else begin
        nxt_ph = PH_ACC;
        nxt_acc = 3'h0;
        nxt_cyc = cyc_ff + 2'h1;
      end
      PH_STORE: begin
        nxt_ph = PH_SEL;
        nxt_idx = idx_ff + 4'h1;
      end
      PH_PROC: nxt_ph = PH_WAIT;
      PH_WAIT: if (mode_ff == MD_SLEEP || tmr_ff >= per_cur) begin
        nxt_ph = PH_IDLE;
      end
      default: nxt_ph = PH_IDLE;
    endcase
  end

  // front end strobes for the next phase
  always_comb begin
    nxt_afe.sel = nxt_idx;
    nxt_afe.clr = (ph_ff == PH_SEL) && (nxt_ph == PH_ACC);
    nxt_afe.accum = (nxt_ph == PH_ACC);
    nxt_afe.dac_en = (nxt_ph == PH_DAC);
    nxt_afe.xfer = (nxt_ph == PH_XFR);
    nxt_afe.dac = (nxt_idx < 4'(NS)) ? dcv_ff[nxt_idx] : '0;
  end

  // sequencer state and period timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_ff <= PH_IDLE;
      idx_ff <= 4'h0;
      cyc_ff <= 2'h0;
      acc_ff <= 3'h0;
      afe_ff <= '0;
      msc_ff <= 16'h0000;
      tmr_ff <= 16'h0000;
    end else begin
      ph_ff <= nxt_ph;
      idx_ff <= nxt_idx;
      cyc_ff <= nxt_cyc;
      acc_ff <= nxt_acc;
      afe_ff <= nxt_afe;
      msc_ff <= (ph_ff != PH_WAIT || msc_ff == MS_LAST) ?
        16'h0000 : msc_ff + 16'h0001;
      if (ph_ff != PH_WAIT) tmr_ff <= 16'h0000;
      else if (msc_ff == MS_LAST) tmr_ff <= tmr_ff + 16'h0001;
    end
  end

  // conversion results
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NS; i++) tick_ff[i] <= '0;
    end else if (ph_ff == PH_STORE && !last) begin
      tick_ff[idx_ff] <= afe_ticks;
    end
  end

  // on/off decision with hysteresis, buttons and wheel inputs alike
  wire [15:0] thr = thr_ff[15:0];
  wire [15:0] hys = thr_ff[F_HI +: 16];
  wire [16:0] thr_hi = {1'b0, thr} + {1'b0, hys};
  wire [15:0] thr_lo = (thr > hys) ? thr - hys : 16'h0000;
  for (genvar g = 0; g < NS; g++) begin : g_dec
    assign nxt_on[g] = en_ff[g] & (on_ff[g] ?
      (tick_ff[g] >= thr_lo) :
      ({1'b0, tick_ff[g]} >= thr_hi));
  end

  // wheel centre of gravity, rank zero at lowest input
  wire [15:0] wmax = wpos_ff[15:0];
  wire [15:0] step = wpos_ff[F_HI +: 16];
  always_comb begin
    num = 24'h0;
    den = 20'h0;
    rank = 4'h0;
    for (int i = 0; i < NS; i++) begin
      if (whl_ff[i] && en_ff[i]) begin
        num = num + 24'(tick_ff[i]) * 24'(rank);
        den = den + 20'(tick_ff[i]);
        rank = rank + 4'h1;
      end
    end
    pos_w = (den == 20'h0 || rank < 4'h2) ? 40'h0 :
      (40'(num) * 40'(wmax)) / (40'(den) * 40'(rank - 4'h1));
  end
  wire [15:0] cog = (pos_w > 40'(wmax)) ? wmax : pos_w[15:0];
  wire wh_on_n = |(nxt_on & whl_ff);
  wire cw_n = wh_on_n & wh_on_ff & (cog > pos_ff)
    & ((cog - pos_ff) >= step);
  wire ccw_n = wh_on_n & wh_on_ff & (pos_ff > cog)
    & ((pos_ff - cog) >= step);
  wire [16:0] nxt_stat = {mode_ff, ccw_n, cw_n, wh_on_n, nxt_on};

  // status, position and interrupt, refreshed in processing only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      on_ff <= 12'h000;
      pos_ff <= 16'h0000;
      wh_on_ff <= 1'b0;
      cw_ff <= 1'b0;
      ccw_ff <= 1'b0;
      stat_ff <= '0;
      irq_n_ff <= 1'b1;
    end else if (ph_ff == PH_PROC) begin
      on_ff <= nxt_on;
      if (wh_on_n) pos_ff <= cog;
      wh_on_ff <= wh_on_n;
      cw_ff <= cw_n;
      ccw_ff <= ccw_n;
      stat_ff <= nxt_stat;
      irq_n_ff <= (nxt_stat == stat_ff);
    end
  end

  // operating mode, inactivity timeout and wake sequence
  wire [11:0] btn = en_ff & ~whl_ff;
  wire [11:0] rel = on_ff & ~nxt_on & btn;
  wire [3:0] wk_exp = wake_ff[{wk_ff[1:0], 2'b00} +: 4];
  wire wk_hit = (rel == (12'h001 << wk_exp));
  wire wk_en = wake_ff[WK_EN];
  wire [2:0] wk_len = wake_ff[WK_LEN +: 3];
  wire wk_done = wk_hit & ((wk_ff + 3'h1) >= wk_len);
  wire wake_go = wk_en ? wk_done : |(nxt_on & btn);
  wire [15:0] idle_n = (|nxt_on) ? 16'h0000 : idle_ff + 16'h0001;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= MD_ACT;
      idle_ff <= 16'h0000;
      wk_ff <= 3'h0;
    end else if (we_mode) begin
      mode_ff <= tbw_mode_e'(wdata_ff[1:0]);
      idle_ff <= 16'h0000;
      wk_ff <= 3'h0;
    end else if (ph_ff == PH_PROC) begin
      idle_ff <= (mode_ff == MD_ACT) ? idle_n : 16'h0000;
      if (mode_ff == MD_ACT && tmo_ff != 16'h0000
          && idle_n >= tmo_ff) begin
        mode_ff <= MD_DOZE;
      end
      if (mode_ff == MD_DOZE && wake_go) mode_ff <= MD_ACT;
      if (mode_ff != MD_DOZE || wk_done || (|rel && !wk_hit)) begin
        wk_ff <= 3'h0;
      end else if (wk_hit) begin
        wk_ff <= wk_ff + 3'h1;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign afe_ctl = afe_ff;
  assign host_interrupt_n = irq_n_ff;

  // checks on the design's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_skip;
    ph_ff == PH_SEL && !last && !en_ff[idx_ff]
      |=> ph_ff == PH_SEL && idx_ff == $past(idx_ff) + 4'h1;
  endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_on;
    ph_ff == PH_PROC && en_ff[0] && !on_ff[0]
      && {1'b0, tick_ff[0]} >= thr_hi |=> on_ff[0];
  endproperty
  a_on: assert property (p_on) else $error("touch missed");
  property p_hold;
    ph_ff == PH_PROC && en_ff[0] && on_ff[0]
      && tick_ff[0] >= thr_lo |=> on_ff[0];
  endproperty
  a_hold: assert property (p_hold) else $error("early off");
  property p_stat;
    $changed(stat_ff) || $fell(irq_n_ff) |-> $past(ph_ff) == PH_PROC;
  endproperty
  a_stat: assert property (p_stat) else $error("late status");
  property p_host;
    we_mode |=> mode_ff == $past(wdata_ff[1:0]);
  endproperty
  a_host: assert property (p_host) else $error("mode cmd");
  property p_cw;
    $rose(cw_ff) |-> {1'b0, pos_ff} >=
      {1'b0, $past(pos_ff)} + {1'b0, step};
  endproperty
  a_cw: assert property (p_cw) else $error("small step");
  property p_clr;
    ph_ff == PH_PROC && !wh_on_n |=> !cw_ff && !ccw_ff;
  endproperty
  a_clr: assert property (p_clr) else $error("stale rot");
  property p_wake;
    ph_ff == PH_PROC && mode_ff == MD_DOZE && !wk_en
      && |(nxt_on & btn) && !we_mode |=> mode_ff == MD_ACT;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_seq;
    ph_ff == PH_PROC && mode_ff == MD_DOZE && wk_en && !wk_done
      && !we_mode |=> mode_ff == MD_DOZE;
  endproperty
  a_seq: assert property (p_seq) else $error("bad wake");
  property p_max;
    ph_ff == PH_PROC |=> pos_ff <= wmax;
  endproperty
  a_max: assert property (p_max) else $error("pos range");
endmodule

// ===== verification/tbw_afe_model.sv
// behavioural analog front end for the touch detector
// assumes strobes in tbw_afe_s change on the rising clock edge
module tbw_afe_model import tbw_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire tbw_afe_s afe_ctl,
  input wire logic [TW-1:0] base [NS],
  output logic [TW-1:0] afe_ticks
);
  timeunit 1ns;
  timeprecision 1ns;
  int scans;
  int xfer_cnt;
  int xfer_n [NS];
  logic [TW-1:0] dac_seen [NS];
  logic [NS-1:0] seen_ff;
  logic [NS-1:0] last_mask;
  logic [3:0] prev_sel;
  logic [TW-1:0] res;
  // result grows with each charge transfer of the sensor
  assign res = TW'(base[afe_ctl.sel] * xfer_cnt);
  // mid-conversion the result is not valid, so show its inverse
  assign afe_ticks = (afe_ctl.clr | afe_ctl.accum | afe_ctl.dac_en |
                      afe_ctl.xfer) ? ~res : res;
  // count transfers, scans, measured inputs and offset levels
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scans <= 0;
      xfer_cnt <= 0;
      seen_ff <= '0;
      last_mask <= '0;
      prev_sel <= 4'hf;
    end else begin
      if (afe_ctl.clr) begin
        xfer_cnt <= 0;
        prev_sel <= afe_ctl.sel;
        if (afe_ctl.sel <= prev_sel) begin
          scans <= scans + 1;
          last_mask <= seen_ff;
          seen_ff <= NS'(1) << afe_ctl.sel;
        end else begin
          seen_ff <= seen_ff | (NS'(1) << afe_ctl.sel);
        end
      end
      if (afe_ctl.xfer) begin
        xfer_cnt <= xfer_cnt + 1;
        xfer_n[afe_ctl.sel] <= xfer_cnt + 1;
      end
      if (afe_ctl.dac_en) begin
        dac_seen[afe_ctl.sel] <= afe_ctl.dac;
      end
    end
  end
endmodule

// ===== verification/testbench.sv
// self-checking bench for the touch button and wheel detector
// assumes tbw_detect and the front end model; AXI4-Lite master here
module testbench import tbw_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic resetn = 0;
  logic [AW-1:0] awaddr = '0;
  logic [AW-1:0] araddr = '0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, irq_n;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, rd;
  logic [TW-1:0] base [NS] = '{default: 16'h0000};
  logic [TW-1:0] afe_ticks;
  tbw_afe_s afe_ctl;
  int n_fail = 0;
  int checks_done = 0;

  tbw_detect #(.MS_CYC(4)) tbw_detect_inst (.clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .afe_ctl(afe_ctl),
    .afe_ticks(afe_ticks), .host_interrupt_n(irq_n));
  tbw_afe_model tbw_afe_model_inst (.clk(clk), .resetn(resetn),
    .afe_ctl(afe_ctl), .base(base), .afe_ticks(afe_ticks));

  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] exp);
    rdr(a, rd, rr);
    chk(what, exp, rd & m);
  endtask

  task automatic scan_wait(input int k);
    int s;
    s = tbw_afe_model_inst.scans;
    while (tbw_afe_model_inst.scans < s + k) begin
      @(posedge clk);
    end
  endtask

  // new ticks from a scan start, then one whole scan and its processing
  task automatic apply(input int ia, input logic [15:0] va, input int ib,
                       input logic [15:0] vb);
    scan_wait(1);
    for (int i = 0; i < NS; i++) begin
      base[i] <= (i == ia) ? va : (i == ib) ? vb : 16'h0000;
    end
    scan_wait(1);
    repeat (2) @(posedge clk);
  endtask

  task automatic t_regs;
    rchk("mode", A_MODE, 32'h3, 32'h0);
    rchk("enable", A_EN, 32'hfff, 32'(EN_RST));
    rchk("wheel mask", A_WHL, 32'hfff, 32'(WHL_RST));
    rchk("threshold", A_THR, 32'hffffffff, THR_RST);
    rdr(8'h40, rd, rr);
    chk("unmapped rresp", 32'(RESP_ERR), 32'(rr));
    chk("unmapped rdata", 32'h0, rd);
    wr(8'h40, 32'h1, RESP_ERR);
    wr(A_PER, 32'h0001_0001, RESP_OK);
    $display("test regs done");
  endtask

  task automatic t_scan;
    wr(A_EN, 32'h0a5, RESP_OK);
    wr(A_SENS, 32'h3, RESP_OK);
    wr(A_DCV, 32'h0002_1234, RESP_OK);
    apply(0, 16'h14, 2, 16'h14);
    chk("scan mask", 32'h0a5, 32'(tbw_afe_model_inst.last_mask));
    chk("xfers 0", 32'h4, tbw_afe_model_inst.xfer_n[0]);
    chk("xfers 2", 32'h1, tbw_afe_model_inst.xfer_n[2]);
    chk("dac 2", 32'h1234, 32'(tbw_afe_model_inst.dac_seen[2]));
    rchk("on bits", A_STAT, 32'hfff, 32'h001);
    wr(A_EN, 32'hfff, RESP_OK);
    wr(A_SENS, 32'h0, RESP_OK);
    $display("test scan done");
  endtask

  task automatic t_hyst;
    logic [15:0] tv [4];
    logic [3:0] on;
    logic prev;
    tv = '{16'h0047, 16'h0048, 16'h0038, 16'h0037};
    on = 4'b0110;
    prev = 1'b0;
    apply(1, 16'h0, 1, 16'h0);
    for (int i = 0; i < 4; i++) begin
      apply(1, tv[i], 1, tv[i]);
      chk("interrupt", 32'(on[i] == prev), 32'(irq_n));
      rchk("button 1", A_STAT, 32'h2, {30'h0, on[i], 1'b0});
      prev = on[i];
    end
    $display("test hysteresis done");
  endtask

  task automatic wstep(input int ia, input logic [15:0] va, input int ib,
                       input logic [15:0] vb, input logic [2:0] f,
                       input logic [15:0] p);
    apply(ia, va, ib, vb);
    rchk("wheel flags", A_STAT, 32'h7000, {17'h0, f, 12'h0});
    rchk("wheel pos", A_POS, 32'hffff, {16'h0, p});
  endtask

  task automatic t_wheel;
    wstep(6, 16'h60, 6, 16'h60, 3'b001, 16'h0000);
    wstep(11, 16'h60, 11, 16'h60, 3'b011, 16'h00ff);
    wstep(11, 16'h60, 11, 16'h60, 3'b001, 16'h00ff);
    wstep(8, 16'h60, 9, 16'h60, 3'b101, 16'h007f);
    wstep(8, 16'h60, 9, 16'h64, 3'b001, 16'h0080);
    wstep(0, 16'h0, 0, 16'h0, 3'b000, 16'h0080);
    $display("test wheel done");
  endtask

  task automatic t_mode;
    int s;
    wr(A_MODE, 32'h1, RESP_OK);
    rchk("mode forced", A_MODE, 32'h3, 32'h1);
    apply(1, 16'h60, 1, 16'h60);
    rchk("mode touch", A_MODE, 32'h3, 32'h0);
    apply(0, 16'h0, 0, 16'h0);
    wr(A_WAKE, 32'h8002_0021, RESP_OK);
    wr(A_MODE, 32'h1, RESP_OK);
    apply(2, 16'h60, 2, 16'h60);
    apply(0, 16'h0, 0, 16'h0);
    rchk("wrong order", A_MODE, 32'h3, 32'h1);
    apply(1, 16'h60, 1, 16'h60);
    apply(0, 16'h0, 0, 16'h0);
    rchk("half sequence", A_MODE, 32'h3, 32'h1);
    apply(2, 16'h60, 2, 16'h60);
    apply(0, 16'h0, 0, 16'h0);
    rchk("full sequence", A_MODE, 32'h3, 32'h0);
    wr(A_WAKE, 32'h0, RESP_OK);
    wr(A_TMO, 32'h2, RESP_OK);
    scan_wait(5);
    rchk("timeout", A_MODE, 32'h3, 32'h1);
    wr(A_TMO, 32'h0, RESP_OK);
    wr(A_MODE, 32'h0, RESP_OK);
    scan_wait(5);
    rchk("timeout off", A_MODE, 32'h3, 32'h0);
    wr(A_MODE, 32'h2, RESP_OK);
    rchk("sleep", A_MODE, 32'h3, 32'h2);
    // let a scan already under way finish before counting
    repeat (150) @(posedge clk);
    s = tbw_afe_model_inst.scans;
    repeat (300) @(posedge clk);
    chk("sleep scans", s, tbw_afe_model_inst.scans);
    wr(A_MODE, 32'h3, RESP_OK);
    rchk("mode 3 ignored", A_MODE, 32'h3, 32'h2);
    wr(A_MODE, 32'h0, RESP_OK);
    $display("test mode done");
  endtask

  // reset, then the scenarios in order
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_scan;
    t_hyst;
    t_wheel;
    t_mode;
    final_report;
  end

  // about 50 short scans plus register traffic fit well inside 1 ms
  initial begin
    #1000000;
    n_fail++;
    final_report;
  end
endmodule
